//--- core/ebc_bus_ctrl.v
// Function
// (R1) Both acknowledges negated: insert wait states, keep cycle running.
// (R2) Only low acknowledge asserted: finish cycle as 8-bit port.
// (R3) Only high acknowledge asserted: finish cycle as 16-bit port.
// (R4) Both asserted: reserved, treated as 16-bit port, usable for DMA.
// (R5) Address strobe marks valid address, space, size, direction.
// (R6) Data strobe requests read data, or marks valid write data.
// (R7) Size code gives bytes remaining: 01,10,11,00 for 1,2,3,4.
// (R8) Direction high for read, low for write.
// (R9) External requester pulls shared active-low request line.
// (R10) Grant output asserted low once master releases the bus.
// (R11) New master holds grant acknowledge low while it owns bus.
// (R12) Locked flag held over all cycles of read-modify-write.
// (R13) System reset resets all; instruction reset only externals.
// (R14) Driven reset line held at least 512 clocks.
// (R15) Suspend line halts bus; with bus fault requests retry.
// (R16) Suspend driven as output on double bus fault.
// (R17) Bus fault alone reports error; with suspend demands retry.
// (R18) Clock source select sampled at reset: high VCO, low crystal.
// (R19) System clock output, slowable in low-power stop.
// (R20) Breakpoint input low signals break; freeze high in background.
// (R21) Two active-low tracking outputs: prefetch and pipeline.
// (R22) Asynchronous handshake inputs synchronised before use.
//
// Bus master sequencer for the external asynchronous bus. The core side
// requests one transfer at a time; pins use separate in/out/oe signals.
`include "ebc_defs.vh"
module ebc_bus_ctrl (
    input  wire        clk_in,
    input  wire        resetn_in,
    // Core side
    input  wire        req_in,
    input  wire        read_in,
    input  wire        locked_in,
    input  wire        lock_end_in,
    input  wire [1:0]  size_in,
    input  wire [3:0]  space_in,
    input  wire        sys_reset_in,
    input  wire        instr_reset_in,
    input  wire        double_fault_in,
    input  wire        low_power_in,
    input  wire        frozen_in,
    input  wire        prefetch_in,
    input  wire        pipe_move_in,
    output wire        ready_out,
    output reg         done_out,
    output reg         fault_out,
    output reg         retry_out,
    output reg  [1:0]  port_size_out,
    output reg         dma32_out,
    output reg         clk_sel_vco_out,
    output reg         ext_reset_out,
    output reg         periph_reset_out,
    output reg         core_reset_out,
    output wire        break_req_out,
    // Pins
    input  wire        size_ack_high_n_in,
    input  wire        size_ack_low_n_in,
    input  wire        bus_fault_in_n_in,
    input  wire        mastership_request_n_in,
    input  wire        grant_acknowledge_n_in,
    input  wire        breakpoint_request_n_in,
    input  wire        clock_source_select_in,
    input  wire        reset_pin_in,
    input  wire        halt_pin_in,
    output wire        reset_pin_out,
    output wire        reset_pin_oe_out,
    output wire        halt_pin_out,
    output wire        halt_pin_oe_out,
    output reg         address_strobe_n_out,
    output reg         data_strobe_n_out,
    output reg         transfer_size_high_out,
    output reg         transfer_size_low_out,
    output reg         read_write_out,
    output reg  [3:0]  address_space_code_out,
    output reg         locked_cycle_flag_n_out,
    output reg         bus_grant_out_n_out,
    output reg         freeze_out,
    output reg         prefetch_indicator_n_out,
    output reg         pipeline_track_n_out,
    output wire        system_clock_output_out
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_ADDR  = 3'h1;
    localparam ST_DATA  = 3'h2;
    localparam ST_END   = 3'h3;
    localparam ST_GRANT = 3'h4;
    // Grant has a state of its own, so no cycle can start under a grant

    wire [6:0] pins_sync;
    wire       ack_high_n = pins_sync[0];
    wire       ack_low_n  = pins_sync[1];
    wire       fault_n    = pins_sync[2];
    wire       request_n  = pins_sync[3];
    wire       gack_n     = pins_sync[4];
    wire       breakpoint_request_n     = pins_sync[5];
    wire       halt_n     = pins_sync[6];

    // Every asynchronous handshake input goes through the synchroniser
    ebc_sync #(
        .WIDTH    (7)
    ) u_sync (
        .clk_in   (clk_in),
        .resetn_in(resetn_in),
        .async_in ({halt_pin_in, breakpoint_request_n_in,
                    grant_acknowledge_n_in, mastership_request_n_in,
                    bus_fault_in_n_in, size_ack_low_n_in,
                    size_ack_high_n_in}),
        .sync_out (pins_sync)
    ); // R22

    // Low-power stop slows the reference by a fixed divisor; devices timed
    // from it must tolerate the step in rate
    ebc_system_clock_output u_system_clock_output (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .half_period_in(low_power_in ? 4'h8 : 4'h1),
        .clk_out       (system_clock_output_out)
    ); // R19

    reg  [2:0] state;
    reg  [2:0] next_state;
    reg        locked;
    reg  [`EBC_RESET_CNT_W-1:0] reset_count;
    reg        reset_drive;
    reg        reset_kind_sys;
    reg        strap_taken;

    wire [1:0] ack_code  = {ack_high_n, ack_low_n};
    wire       ack_seen  = (ack_code != `EBC_ACK_WAIT); // R1
    wire       halted    = !halt_n && fault_n; // R15
    wire       retry_now = !fault_n && !halt_n; // R15 R17
    wire       fault_now = !fault_n && halt_n; // R17
    // A slave lets go of its code only once the strobe rises, and the
    // synchroniser shows that some cycles later; a cycle started before
    // then would end at once on the stale code
    wire       bus_quiet = !ack_seen && fault_n; // R1
    // A begun locked sequence stays locked until the core marks its last
    // cycle; a later request without the lock cannot open it
    wire       lock_next = locked || locked_in; // R12

    assign ready_out     = (state == ST_IDLE) && !halted && request_n &&
                           bus_quiet;
    assign break_req_out = !breakpoint_request_n; // R20

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // A locked sequence keeps the bus; request waits for it
                if (!request_n && !locked) begin
                    next_state = ST_GRANT;
                end else if (req_in && !halted && bus_quiet) begin
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: next_state = ST_DATA;
            ST_DATA: begin
                // A fault ends the cycle even when no size code comes
                if (ack_seen || !fault_n) begin
                    next_state = ST_END;
                end
            end
            ST_END: next_state = ST_IDLE;
            ST_GRANT: begin
                // Hold grant until the new master has come and gone
                if (request_n && gack_n) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state                   <= ST_IDLE;
            locked                  <= 1'b0;
            address_strobe_n_out    <= 1'b1;
            data_strobe_n_out       <= 1'b1;
            transfer_size_high_out  <= 1'b0;
            transfer_size_low_out   <= 1'b0;
            read_write_out          <= 1'b1;
            address_space_code_out  <= 4'h0;
            locked_cycle_flag_n_out <= 1'b1;
            bus_grant_out_n_out     <= 1'b1;
            done_out                <= 1'b0;
            fault_out               <= 1'b0;
            retry_out               <= 1'b0;
            port_size_out           <= 2'h0;
            dma32_out               <= 1'b0;
        end else begin
            state     <= next_state;
            done_out  <= 1'b0;
            fault_out <= 1'b0;
            retry_out <= 1'b0;
            if (state == ST_IDLE && next_state == ST_ADDR) begin
                // Space, size and direction settle with the strobe
                address_strobe_n_out   <= 1'b0; // R5
                address_space_code_out <= space_in; // R5
                transfer_size_high_out <= size_in[1]; // R7
                transfer_size_low_out  <= size_in[0]; // R7
                read_write_out         <= read_in; // R8
                locked                 <= lock_next;
                locked_cycle_flag_n_out <= !lock_next; // R12
                // Read asks the slave for data at once
                data_strobe_n_out      <= !read_in; // R6
            end
            if (state == ST_ADDR) begin
                // Write data is on the bus one cycle after the address
                data_strobe_n_out <= 1'b0; // R6
            end
            if (state == ST_DATA && next_state == ST_END) begin
                address_strobe_n_out <= 1'b1;
                data_strobe_n_out    <= 1'b1;
                // A fault beside a size code wins: the data is not trusted
                done_out             <= ack_seen && fault_n;
                fault_out            <= fault_now; // R17
                retry_out            <= retry_now; // R15
                dma32_out            <= (ack_code == `EBC_ACK_RESERVED); // R4
                case (ack_code)
                    `EBC_ACK_PORT8:    port_size_out <= 2'h1; // R2
                    `EBC_ACK_PORT16:   port_size_out <= 2'h2; // R3
                    `EBC_ACK_RESERVED: port_size_out <= 2'h2; // R4
                    default:           port_size_out <= 2'h0;
                endcase
            end
            if (state == ST_END && (lock_end_in || !locked)) begin
                locked                  <= 1'b0;
                locked_cycle_flag_n_out <= 1'b1; // R12
            end
            bus_grant_out_n_out <= !(next_state == ST_GRANT); // R10 R9 R11
        end
    end

    // Reset line drive: hold for exactly the minimum count. A trigger
    // that arrives while the line is driven is dropped, not restarted,
    // so a stream of triggers cannot hold the line down for ever.
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reset_count      <= {`EBC_RESET_CNT_W{1'b0}};
            reset_drive      <= 1'b0;
            reset_kind_sys   <= 1'b0;
            ext_reset_out    <= 1'b0;
            periph_reset_out <= 1'b0;
            core_reset_out   <= 1'b0;
        end else begin
            ext_reset_out    <= 1'b0;
            periph_reset_out <= 1'b0;
            core_reset_out   <= 1'b0;
            if (!reset_drive && (sys_reset_in || instr_reset_in)) begin
                reset_drive    <= 1'b1;
                reset_kind_sys <= sys_reset_in;
                reset_count    <= {`EBC_RESET_CNT_W{1'b0}};
            end else if (reset_drive) begin
                ext_reset_out    <= 1'b1; // R13
                periph_reset_out <= 1'b1; // R13
                core_reset_out   <= reset_kind_sys; // R13
                if (reset_count == `EBC_RESET_MIN_CYC - 1) begin
                    reset_drive <= 1'b0; // R14
                end else begin
                    reset_count <= reset_count + 10'h001;
                end
            end
        end
    end

    assign reset_pin_out    = 1'b0;
    assign reset_pin_oe_out = reset_drive; // R14
    assign halt_pin_out     = 1'b0;
    assign halt_pin_oe_out  = double_fault_in; // R16
    // Both open-drain pins only pull low; the pull-up gives the high level

    // Strap is caught by the first clocked edge after release. The pin is
    // read raw: it is held steady through reset, so no synchroniser delay
    // is worth paying here.
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            strap_taken     <= 1'b0;
            clk_sel_vco_out <= 1'b1;
        end else if (!strap_taken) begin
            strap_taken     <= 1'b1;
            clk_sel_vco_out <= clock_source_select_in; // R18
        end
    end

    // Debug and tracking pins are registered so that they change with the
    // clock edge that external tools sample against
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            freeze_out               <= 1'b0;
            prefetch_indicator_n_out <= 1'b1;
            pipeline_track_n_out     <= 1'b1;
        end else begin
            freeze_out               <= frozen_in; // R20
            prefetch_indicator_n_out <= !prefetch_in; // R21
            pipeline_track_n_out     <= !pipe_move_in; // R21
        end
    end
endmodule

//--- core/ebc_sync.v
// Three-stage synchroniser for active-low pins; output changes once the
// second and third stages agree. Assumes one clock, async low reset.
module ebc_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_in,
    input  wire             resetn_in,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    stage1[i]   <= 1'b1;
                    stage2[i]   <= 1'b1;
                    stage3[i]   <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i]) begin
                        sync_out[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule

//--- core/ebc_system_clock_output.v
// System clock output divider; divisor 1 passes the clock through as a
// toggle at half rate. Assumes divisor changes only between periods.
`include "ebc_defs.vh"
module ebc_system_clock_output (
    input  wire                     clk_in,
    input  wire                     resetn_in,
    input  wire [`EBC_CLKDIV_W-1:0] half_period_in,
    output reg                      clk_out
);
    reg [`EBC_CLKDIV_W-1:0] count;
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count   <= {`EBC_CLKDIV_W{1'b0}};
            clk_out <= 1'b0;
        end else if (count + 4'h1 >= half_period_in) begin
            count   <= {`EBC_CLKDIV_W{1'b0}};
            clk_out <= ~clk_out;
        end else begin
            count <= count + 4'h1;
        end
    end
endmodule

//--- pkg/ebc_defs.vh
// Constants for the external bus control block.
// Assumes inclusion by bare name from core files.
`ifndef EBC_DEFS_VH
`define EBC_DEFS_VH
`define EBC_SIZE_LONG      2'h0
`define EBC_SIZE_BYTE      2'h1
`define EBC_SIZE_WORD      2'h2
`define EBC_SIZE_THREE     2'h3
`define EBC_ACK_WAIT       2'h3
`define EBC_ACK_PORT8      2'h2
`define EBC_ACK_PORT16     2'h1
`define EBC_ACK_RESERVED   2'h0
`define EBC_RESET_MIN_CYC  512
`define EBC_RESET_CNT_W    10
`define EBC_CLKDIV_W       4
`endif

//--- testbench/ebc_bus_ctrl_checker.sv
// Concurrent checks on the bus control block, seen from its top ports.
// Assumes one clock domain with an asynchronous active-low reset.
module ebc_bus_ctrl_checker (
    input wire logic       clk_in,
    input wire logic       resetn_in,
    input wire logic       req_in,
    input wire logic       read_in,
    input wire logic [1:0] size_in,
    input wire logic [3:0] space_in,
    input wire logic [3:0] address_space_code_out,
    input wire logic       ready_out,
    input wire logic       clock_source_select_in,
    input wire logic       size_ack_high_n_in,
    input wire logic       size_ack_low_n_in,
    input wire logic       bus_fault_in_n_in,
    input wire logic       address_strobe_n_out,
    input wire logic       data_strobe_n_out,
    input wire logic       transfer_size_high_out,
    input wire logic       transfer_size_low_out,
    input wire logic       read_write_out,
    input wire logic       locked_cycle_flag_n_out,
    input wire logic       bus_grant_out_n_out,
    input wire logic       reset_pin_oe_out,
    input wire logic       clk_sel_vco_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] oe_cnt;
    logic       quiet;
    assign quiet = size_ack_high_n_in & size_ack_low_n_in & bus_fault_in_n_in;
    default clocking
        @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    // Counts the current run of reset drive; wraps only beyond 1023
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            oe_cnt <= 10'h000;
        else
            oe_cnt <= reset_pin_oe_out ? oe_cnt + 10'h001 : 10'h000;
    end
    property p_take;
        ready_out && req_in |=> !address_strobe_n_out &&
            {transfer_size_high_out, transfer_size_low_out} == $past(size_in);
    endproperty
    a_take: assert property (p_take) else $error("size code wrong");
    property p_dir;
        ready_out && req_in |=> read_write_out == $past(read_in);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
    property p_space;
        ready_out && req_in |=> address_space_code_out == $past(space_in);
    endproperty
    a_space: assert property (p_space) else $error("space code wrong");
    property p_stable;
        !address_strobe_n_out && $past(!address_strobe_n_out) |->
            $stable({transfer_size_high_out, transfer_size_low_out}) &&
            $stable(read_write_out) && $stable(address_space_code_out);
    endproperty
    a_stable: assert property (p_stable) else $error("qualifier moved");
    property p_dstrobe;
        $fell(address_strobe_n_out) |-> ##[0:1] !data_strobe_n_out;
    endproperty
    a_dstrobe: assert property (p_dstrobe) else $error("data strobe late");
    property p_wait;
        quiet[*5] ##0 !address_strobe_n_out |=> !address_strobe_n_out;
    endproperty
    a_wait: assert property (p_wait) else $error("cycle ended unacked");
    property p_grant;
        !bus_grant_out_n_out |-> address_strobe_n_out && locked_cycle_flag_n_out;
    endproperty
    a_grant: assert property (p_grant) else $error("grant while busy");
    property p_lock;
        !address_strobe_n_out |-> !$rose(locked_cycle_flag_n_out);
    endproperty
    a_lock: assert property (p_lock) else $error("lock released");
    property p_rst;
        $fell(reset_pin_oe_out) |-> oe_cnt >= 10'h200;
    endproperty
    a_rst: assert property (p_rst) else $error("reset drive short");
    property p_strap;
        $rose(resetn_in) |=> clk_sel_vco_out == $past(clock_source_select_in);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not taken");
endmodule

bind ebc_bus_ctrl ebc_bus_ctrl_checker u_chk (.*);

//--- testbench/ebc_slave_model.sv
// Slave on the far side: answers each address strobe with a size code,
// a bus fault, or fault plus suspend. Lines idle high by pull-up.
module ebc_slave_model (
    input  wire logic       clk_in,
    input  wire logic       strobe_n_in,
    input  wire logic [1:0] code_in,
    input  wire logic [3:0] delay_in,
    input  wire logic [1:0] mode_in,
    output logic            ack_high_n_out,
    output logic            ack_low_n_out,
    output logic            fault_n_out,
    output logic            halt_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {ack_high_n_out, ack_low_n_out, fault_n_out, halt_n_out} = 4'hF;
        forever begin
            @(negedge strobe_n_in);
            repeat (delay_in) @(posedge clk_in);
            if (mode_in == 2'h0)
                {ack_high_n_out, ack_low_n_out} <= ~code_in;
            else
                {fault_n_out, halt_n_out} <= {1'b0, mode_in != 2'h2};
            @(posedge strobe_n_in);
            {ack_high_n_out, ack_low_n_out, fault_n_out, halt_n_out} <= 4'hF;
        end
    end
endmodule

//--- testbench/tb_ebc_bus_ctrl.sv
// Self-checking bench for the bus control block with a slave model.
// Bench inputs change at the falling clock edge, slave lines at the rising edge; open-drain pins pulled up.
module tb_ebc_bus_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in, resetn_in, req_in, read_in, locked_in, lock_end_in;
    logic sys_reset_in, instr_reset_in, double_fault_in, low_power_in;
    logic frozen_in, prefetch_in, pipe_move_in, clock_source_select_in;
    logic mastership_request_n_in, grant_acknowledge_n_in;
    logic breakpoint_request_n_in, halt_n;
    logic [1:0] size_in, code, mode, port_size_out;
    logic [3:0] space_in, delay, address_space_code_out;
    logic ready_out, done_out, fault_out, retry_out, dma32_out;
    logic clk_sel_vco_out, ext_reset_out, periph_reset_out, core_reset_out;
    logic break_req_out, reset_pin_out, reset_pin_oe_out, halt_pin_out;
    logic halt_pin_oe_out, address_strobe_n_out, data_strobe_n_out;
    logic transfer_size_high_out, transfer_size_low_out, read_write_out;
    logic locked_cycle_flag_n_out, bus_grant_out_n_out, freeze_out;
    logic prefetch_indicator_n_out, pipeline_track_n_out;
    logic system_clock_output_out;
    logic size_ack_high_n_in, size_ack_low_n_in, bus_fault_in_n_in;
    wire  reset_pin_in = reset_pin_out | ~reset_pin_oe_out;
    wire  halt_pin_in = halt_n & (halt_pin_out | ~halt_pin_oe_out);
    int   fail_count, compares;

    ebc_bus_ctrl DUT (.*);
    ebc_slave_model slave (.clk_in(clk_in), .strobe_n_in(address_strobe_n_out),
        .code_in(code), .delay_in(delay), .mode_in(mode),
        .ack_high_n_out(size_ack_high_n_in), .ack_low_n_out(size_ack_low_n_in),
        .fault_n_out(bus_fault_in_n_in), .halt_n_out(halt_n));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task end_of_test;
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task run_cycle(input logic rd, input logic [1:0] sz, ack, md,
                   output logic [5:0] res);
        int n;
        n = 0;
        while (ready_out !== 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        {read_in, size_in, space_in} = {rd, sz, 2'h1, sz};
        {code, mode, req_in} = {ack, md, 1'b1};
        @(negedge clk_in);
        req_in = 1'b0;
        n = 0;
        while ((done_out | fault_out | retry_out) !== 1'b1 && n < 60) begin
            @(negedge clk_in);
            n++;
        end
        res = {done_out, fault_out, retry_out, dma32_out, port_size_out};
        mode = 2'h0;
    endtask

    task t_sizes;
        logic [5:0] r;
        for (int i = 0; i < 4; i++) begin
            run_cycle(i[0], i[1:0], 2'h1, 2'h0, r);
            chk(r, 8'h21);
        end
    endtask

    task t_ports;
        logic [5:0] r;
        delay = 4'hC;
        run_cycle(1'b0, 2'h0, 2'h2, 2'h0, r);
        chk(r, 8'h22);
        delay = 4'h1;
        run_cycle(1'b1, 2'h3, 2'h3, 2'h0, r);
        chk(r, 8'h26);
        run_cycle(1'b1, 2'h2, 2'h1, 2'h1, r);
        chk(r[5:3], 8'h02);
        run_cycle(1'b0, 2'h1, 2'h1, 2'h2, r);
        chk(r[5:3], 8'h01);
    endtask

    task t_lock;
        logic [5:0] r;
        locked_in = 1'b1;
        run_cycle(1'b1, 2'h2, 2'h2, 2'h0, r);
        locked_in = 1'b0;
        mastership_request_n_in = 1'b0;
        repeat (8) @(negedge clk_in);
        chk({locked_cycle_flag_n_out, bus_grant_out_n_out}, 8'h01);
        mastership_request_n_in = 1'b1;
        lock_end_in = 1'b1;
        run_cycle(1'b0, 2'h2, 2'h2, 2'h0, r);
        @(negedge clk_in);
        lock_end_in = 1'b0;
        chk(locked_cycle_flag_n_out, 8'h01);
    endtask

    task t_grant;
        mastership_request_n_in = 1'b0;
        repeat (8) @(negedge clk_in);
        chk({bus_grant_out_n_out, ready_out}, 8'h00);
        grant_acknowledge_n_in = 1'b0;
        mastership_request_n_in = 1'b1;
        repeat (8) @(negedge clk_in);
        chk(bus_grant_out_n_out, 8'h00);
        grant_acknowledge_n_in = 1'b1;
        repeat (8) @(negedge clk_in);
        chk(bus_grant_out_n_out, 8'h01);
    endtask

    task t_halt;
        double_fault_in = 1'b1;
        repeat (6) @(negedge clk_in);
        chk({halt_pin_oe_out, ready_out}, 8'h02);
        double_fault_in = 1'b0;
        repeat (8) @(negedge clk_in);
        chk(ready_out, 8'h01);
    endtask

    task t_reset(input logic sys);
        int n;
        {sys_reset_in, instr_reset_in} = {sys, ~sys};
        @(negedge clk_in);
        {sys_reset_in, instr_reset_in} = 2'h0;
        repeat (2) @(negedge clk_in);
        chk({ext_reset_out, periph_reset_out, core_reset_out}, {2'h3, sys});
        n = 0;
        while (reset_pin_oe_out === 1'b1 && n < 600) begin
            @(negedge clk_in);
            n++;
        end
        chk(n > 500 && n < 600, 8'h01);
    endtask

    task t_debug;
        {frozen_in, prefetch_in, pipe_move_in, breakpoint_request_n_in} = 4'hE;
        repeat (6) @(negedge clk_in);
        chk({freeze_out, prefetch_indicator_n_out, pipeline_track_n_out,
             break_req_out}, 8'h09);
        {frozen_in, prefetch_in, pipe_move_in, breakpoint_request_n_in} = 4'h1;
        repeat (6) @(negedge clk_in);
        chk({freeze_out, prefetch_indicator_n_out, pipeline_track_n_out,
             break_req_out}, 8'h06);
    endtask

    task t_clock(input logic lp, input logic [7:0] exp);
        int   n;
        logic p;
        low_power_in = lp;
        repeat (20) @(negedge clk_in);
        n = 0;
        repeat (32) begin
            p = system_clock_output_out;
            @(negedge clk_in);
            n += (p != system_clock_output_out);
        end
        chk(n, exp);
    endtask

    initial begin
        #60000;
        fail_count++;
        end_of_test;
    end

    initial begin
        {req_in, read_in, locked_in, lock_end_in} = 4'h0;
        {sys_reset_in, instr_reset_in, double_fault_in, low_power_in} = 4'h0;
        {frozen_in, prefetch_in, pipe_move_in, clock_source_select_in} = 4'h0;
        {mastership_request_n_in, grant_acknowledge_n_in} = 2'h3;
        breakpoint_request_n_in = 1'b1;
        {size_in, code, mode, space_in, delay} = {6'h04, 4'h0, 4'h1};
        resetn_in = 1'b0;
        repeat (8) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk(clk_sel_vco_out, 8'h00);
        clock_source_select_in = 1'b1;
        t_sizes;
        t_ports;
        t_lock;
        t_grant;
        t_halt;
        t_reset(1'b0);
        t_reset(1'b1);
        t_debug;
        t_clock(1'b0, 8'h20);
        t_clock(1'b1, 8'h04);
        chk(clk_sel_vco_out, 8'h00);
        end_of_test;
    end
endmodule
